//--- hw/elc_pkg.sv
package elc_pkg;

  // line count and the line vector type
  localparam int NLINES = 19;
  typedef logic [NLINES-1:0] elc_line_t;

  // register byte addresses
  localparam logic [31:0] OFF_IRQ_MASK  = 32'h0000_0000;
  localparam logic [31:0] OFF_EVT_MASK  = 32'h0000_0004;
  localparam logic [31:0] OFF_RISE_EN   = 32'h0000_0008;
  localparam logic [31:0] OFF_FALL_EN   = 32'h0000_000c;
  localparam logic [31:0] OFF_SW_TRIG   = 32'h0000_0010;
  localparam logic [31:0] OFF_LINE_PEND = 32'h0000_0014;

  // reset values, all control state starts cleared
  localparam elc_line_t RST_LINES = 19'h0_0000;
  localparam logic [12:0] RSVD_ZERO = 13'h0000;

  // bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // axi4-lite master to slave
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } elc_axi_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } elc_axi_rsp_s;

  // trigger sources feeding the lines
  typedef struct packed {
    logic [15:0] pin;
    logic        volt_mon;
    logic        rtc_alarm;
    logic        usb_wake;
  } elc_src_s;

endpackage

//--- hw/elc_ext_line_ctrl.sv
`timescale 1ns/1ps
module elc_ext_line_ctrl
(
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire elc_pkg::elc_axi_req_s bus_req,
  output      elc_pkg::elc_axi_rsp_s bus_rsp,
  input  wire elc_pkg::elc_src_s     src_in,
  output      elc_pkg::elc_line_t    irq_req,
  output      elc_pkg::elc_line_t    evt_pulse
);
  import elc_pkg::*;

  // byte strobes widened to a bit mask
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // line bits of a write, byte lanes applied
  function automatic elc_line_t wr_bits(input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = d & strb_mask(s);
    return m[NLINES-1:0];
  endfunction

  // read-modify-write of a plain register under byte lanes
  function automatic elc_line_t merge(input elc_line_t   old,
                                      input logic [31:0] d,
                                      input logic [3:0]  s);
    logic [31:0] m;
    m = strb_mask(s);
    return (old & ~m[NLINES-1:0]) | (d[NLINES-1:0] & m[NLINES-1:0]);
  endfunction

  logic        aw_have_q, aw_have_d;
  logic [31:0] awaddr_q,  awaddr_d;
  logic        w_have_q,  w_have_d;
  logic [31:0] wdata_q,   wdata_d;
  logic [3:0]  wstrb_q,   wstrb_d;
  logic        bvalid_q,  bvalid_d;
  logic [1:0]  bresp_q,   bresp_d;
  logic        rvalid_q,  rvalid_d;
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic        wr_go;
  logic        aw_ready;
  logic        w_ready;
  logic        ar_ready;
  logic        wr_hit;

  elc_line_t   imask_q,   imask_d;
  elc_line_t   emask_q,   emask_d;
  elc_line_t   rise_q,    rise_d;
  elc_line_t   fall_q,    fall_d;
  elc_line_t   sw_q,      sw_d;
  elc_line_t   pend_q,    pend_d;
  elc_line_t   irq_q,     irq_d;
  elc_line_t   evt_q,     evt_d;
  elc_line_t   sync1_q,   sync1_d;
  elc_line_t   sync2_q,   sync2_d;
  elc_line_t   prev_q,    prev_d;
  elc_line_t   line_raw;
  elc_line_t   rise_hit;
  elc_line_t   fall_hit;
  elc_line_t   edge_hit;
  elc_line_t   any_edge;
  elc_line_t   sw_one;
  elc_line_t   sw_pend;
  elc_line_t   pend_w1c;
  elc_line_t   pol_chg;
  elc_line_t   evt_only;
  elc_line_t   eo_req;
  logic        cfg_wr;

  // address and data channels taken independently, one write at a time
  always_comb
  begin
    aw_ready  = ~aw_have_q;
    w_ready   = ~w_have_q;
    ar_ready  = ~rvalid_q;
    wr_go     = aw_have_q & w_have_q & ~bvalid_q;
    aw_have_d = aw_have_q;
    awaddr_d  = awaddr_q;
    w_have_d  = w_have_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    wr_hit    = (awaddr_q == OFF_IRQ_MASK) || (awaddr_q == OFF_EVT_MASK) ||
                (awaddr_q == OFF_RISE_EN)  || (awaddr_q == OFF_FALL_EN)  ||
                (awaddr_q == OFF_SW_TRIG)  || (awaddr_q == OFF_LINE_PEND);
    if (bus_req.awvalid && aw_ready)
    begin
      aw_have_d = 1'b1;
      awaddr_d  = bus_req.awaddr;
    end
    if (bus_req.wvalid && w_ready)
    begin
      w_have_d = 1'b1;
      wdata_d  = bus_req.wdata;
      wstrb_d  = bus_req.wstrb;
    end
    if (bvalid_q && bus_req.bready)
      bvalid_d = 1'b0;
    if (wr_go)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (rvalid_q && bus_req.rready)
      rvalid_d = 1'b0;
    if (bus_req.arvalid && ar_ready)
    begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      case (bus_req.araddr)
        OFF_IRQ_MASK:  rdata_d = {RSVD_ZERO, imask_q};
        OFF_EVT_MASK:  rdata_d = {RSVD_ZERO, emask_q};
        OFF_RISE_EN:   rdata_d = {RSVD_ZERO, rise_q};
        OFF_FALL_EN:   rdata_d = {RSVD_ZERO, fall_q};
        OFF_SW_TRIG:   rdata_d = {RSVD_ZERO, sw_q};
        OFF_LINE_PEND: rdata_d = {RSVD_ZERO, pend_q};
        default:
        begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= 32'h0000_0000;
      w_have_q  <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      awaddr_q  <= awaddr_d;
      w_have_q  <= w_have_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // fixed source order; glitch-free sources are the driver's duty
  assign line_raw = {src_in.usb_wake, src_in.rtc_alarm, src_in.volt_mon,
                     src_in.pin};

  // two-stage synchroniser, then one more stage as the last sample
  always_comb
  begin
    sync1_d = line_raw;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sync1_q <= RST_LINES;
      sync2_q <= RST_LINES;
      prev_q  <= RST_LINES;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // registers, edge triggers and pending flags
  always_comb
  begin
    imask_d  = imask_q;
    emask_d  = emask_q;
    rise_d   = rise_q;
    fall_d   = fall_q;
    sw_one   = RST_LINES;
    pend_w1c = RST_LINES;
    if (wr_go && awaddr_q == OFF_IRQ_MASK)
      imask_d = merge(imask_q, wdata_q, wstrb_q);
    if (wr_go && awaddr_q == OFF_EVT_MASK)
      emask_d = merge(emask_q, wdata_q, wstrb_q);
    if (wr_go && awaddr_q == OFF_RISE_EN)
      rise_d = merge(rise_q, wdata_q, wstrb_q);
    if (wr_go && awaddr_q == OFF_FALL_EN)
      fall_d = merge(fall_q, wdata_q, wstrb_q);
    if (wr_go && awaddr_q == OFF_SW_TRIG)
      sw_one = wr_bits(wdata_q, wstrb_q);
    if (wr_go && awaddr_q == OFF_LINE_PEND)
      pend_w1c = wr_bits(wdata_q, wstrb_q);
    // any enable write blanks detection for that cycle, even unchanged
    cfg_wr   = wr_go && (awaddr_q == OFF_RISE_EN ||
                         awaddr_q == OFF_FALL_EN);
    pol_chg  = (rise_d ^ rise_q) | (fall_d ^ fall_q);
    rise_hit = sync2_q & ~prev_q & rise_q;
    fall_hit = ~sync2_q & prev_q & fall_q;
    any_edge = rise_q & fall_q & (sync2_q ^ prev_q);
    edge_hit = (rise_hit | fall_hit) & {NLINES{~cfg_wr}};
    evt_only = emask_q & ~imask_q;
    eo_req   = sw_one & evt_only & ~edge_hit;
    sw_pend  = sw_one & ~sw_q & ~evt_only;
    sw_d     = (sw_q | sw_one) & ~pend_w1c;
    // a new trigger beats a clear in the same cycle
    pend_d   = (pend_q & ~pend_w1c & ~pol_chg) |
               edge_hit | sw_pend;
    irq_d    = pend_d & imask_d;
    evt_d    = (edge_hit | sw_one) & emask_q;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      imask_q <= RST_LINES;
      emask_q <= RST_LINES;
      rise_q  <= RST_LINES;
      fall_q  <= RST_LINES;
      sw_q    <= RST_LINES;
      pend_q  <= RST_LINES; // defined value although software may not rely
      irq_q   <= RST_LINES;
      evt_q   <= RST_LINES;
    end
    else
    begin
      imask_q <= imask_d;
      emask_q <= emask_d;
      rise_q  <= rise_d;
      fall_q  <= fall_d;
      sw_q    <= sw_d;
      pend_q  <= pend_d;
      irq_q   <= irq_d;
      evt_q   <= evt_d;
    end
  end

  // outputs
  assign bus_rsp.awready = aw_ready;
  assign bus_rsp.wready  = w_ready;
  assign bus_rsp.bvalid  = bvalid_q;
  assign bus_rsp.bresp   = bresp_q;
  assign bus_rsp.arready = ar_ready;
  assign bus_rsp.rvalid  = rvalid_q;
  assign bus_rsp.rdata   = rdata_q;
  assign bus_rsp.rresp   = rresp_q;
  assign irq_req         = irq_q;
  assign evt_pulse       = evt_q;

  rise_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rise_hit != '0) && !cfg_wr |=>
      (pend_q & $past(rise_hit)) == $past(rise_hit))
    else $error("rising edge did not set pending");
  fall_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    (fall_hit != '0) && !cfg_wr |=>
      ((pend_q & $past(fall_hit)) == $past(fall_hit)) &&
      ((evt_pulse & $past(fall_hit)) == ($past(fall_hit) & $past(emask_q))))
    else $error("falling edge not taken");
  both_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
    (any_edge != '0) && !cfg_wr |=>
      (pend_q & $past(any_edge)) == $past(any_edge))
    else $error("dual edge line missed an edge");
  cfg_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_wr |=> ((pend_q & ~$past(pend_q)) == '0) && (evt_pulse == '0))
    else $error("edge recognised during enable write");
  sw_evt_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sw_one != '0) |=>
      (evt_pulse & $past(sw_one)) == ($past(sw_one) & $past(emask_q)))
    else $error("software request not forwarded as event");
  sw_pend_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sw_pend != '0) |=> (pend_q & $past(sw_pend)) == $past(sw_pend))
    else $error("software trigger did not set pending");
  evt_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    (eo_req != '0) |=> (pend_q & ~$past(pend_q) & $past(eo_req)) == '0)
    else $error("event-only request set pending");
  w1c_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pend_w1c != '0) && (edge_hit == '0) |=>
      ((pend_q | sw_q) & $past(pend_w1c)) == '0)
    else $error("write one to pending left bits set");
  pol_clr_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_wr |=> (pend_q & $past(pol_chg)) == '0)
    else $error("polarity change did not clear pending");
  pend_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (pend_w1c == '0) && !cfg_wr |=> (pend_q & $past(pend_q)) == $past(pend_q))
    else $error("pending flag dropped without clear");
  // with no write, pending only gains edges and the mask alone gates it
  irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    !wr_go |=> irq_req == ($past(pend_q | edge_hit) & imask_q))
    else $error("interrupt request not gated by mask");
  rsvd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    bus_rsp.rvalid |-> bus_rsp.rdata[31:19] == RSVD_ZERO)
    else $error("reserved read bits not zero");
  // every stage must have been out of reset for the chain to be full
  sync_lat_a: assert property (@(posedge clk) disable iff (!reset_n)
    $past(reset_n) && $past(reset_n, 2) && $past(reset_n, 3) |->
      prev_q == $past(line_raw, 3))
    else $error("line sample chain latency wrong");

endmodule

//--- test/elc_src_model.sv
`timescale 1ns/1ps
// trigger sources standing in for pins, monitor, alarm and usb wake
module elc_src_model
(
  input  wire elc_pkg::elc_line_t lvl,
  input  wire logic               clk,
  output elc_pkg::elc_src_s       src
);
  import elc_pkg::*;

  // registered, so a level is clean for a whole cycle and never glitches
  always_ff @(posedge clk)
  begin
    src <= {lvl[15:0], lvl[16], lvl[17], lvl[18]};
  end
endmodule

//--- test/elc_ext_line_ctrl_tb_top.sv
`timescale 1ns/1ps
module elc_ext_line_ctrl_tb_top;
  import elc_pkg::*;

  // line, rise enable, fall enable, start level, end level, pending
  typedef struct packed
  {
    logic [4:0] ln;
    logic       r;
    logic       f;
    logic       a;
    logic       b;
    logic       p;
  } elc_row_s;

  logic         clk;
  logic         reset_n;
  elc_axi_req_s req;
  elc_axi_rsp_s rsp;
  elc_src_s     src;
  elc_line_t    lvl;
  elc_line_t    irq;
  elc_line_t    evt;
  elc_line_t    acc;
  logic         acc_clr;
  logic [31:0]  d;
  logic [1:0]   rs;
  int           miscompares;
  int           check_count;
  int           k;
  elc_row_s     rows [7] = '{
    '{5'd3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1},
    '{5'd4, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{5'd15, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
    '{5'd16, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0},
    '{5'd17, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1},
    '{5'd18, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
    '{5'd0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0}};

  elc_ext_line_ctrl u_elc_ext_line_ctrl (.clk(clk), .reset_n(reset_n),
    .bus_req(req), .bus_rsp(rsp), .src_in(src), .irq_req(irq),
    .evt_pulse(evt));
  elc_src_model u_elc_src_model (.lvl(lvl), .clk(clk), .src(src));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // event pulses last one cycle, so gather them until cleared
  always_ff @(posedge clk)
  begin
    acc <= acc_clr ? '0 : (acc | evt);
  end

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // address and data offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v,
                    input logic [1:0] er = 2'h0,
                    input logic [3:0] st = 4'hf);
    int   i;
    logic ta;
    logic tw;
    logic tb;
    @(posedge clk);
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= v;
    req.wstrb   <= st;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      tb = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge clk);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb)
      begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (i == 40)
    begin
      miscompares++;
      finish_test();
    end
    else
      chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    int   i;
    logic ta;
    logic tr;
    @(posedge clk);
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (i = 0; i < 40; i++)
    begin
      @(negedge clk);
      ta = req.arvalid & rsp.arready;
      tr = rsp.rvalid;
      d  = rsp.rdata;
      rs = rsp.rresp;
      @(posedge clk);
      if (ta) req.arvalid <= 1'b0;
      if (tr)
      begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (i == 40)
    begin
      miscompares++;
      finish_test();
    end
    else
    begin
      chk(d, e);
      chk({30'h0, rs}, {30'h0, er});
    end
  endtask

  initial
  begin
    req         = '0;
    lvl         = '0;
    reset_n     = 1'b0;
    acc_clr     = 1'b1;
    miscompares = 0;
    check_count = 0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    acc_clr <= 1'b0;
    // everything reads cleared after reset, outputs quiet
    for (k = 0; k < 6; k++)
      rd(32'(4 * k), 32'h0);
    chk({13'h0, irq | evt}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0007_ffff);
    // edge table: one line per row, interrupt mask open
    foreach (rows[i])
    begin
      lvl[rows[i].ln] <= rows[i].a;
      repeat (5) @(posedge clk);
      wr(OFF_RISE_EN, 32'(rows[i].r) << rows[i].ln);
      wr(OFF_FALL_EN, 32'(rows[i].f) << rows[i].ln);
      wr(OFF_LINE_PEND, 32'h0007_ffff);
      lvl[rows[i].ln] <= rows[i].b;
      repeat (6) @(posedge clk);
      rd(OFF_LINE_PEND, 32'(rows[i].p) << rows[i].ln);
      chk({13'h0, irq}, 32'(rows[i].p) << rows[i].ln);
    end
    // reserved bits and unmapped place
    wr(OFF_RISE_EN, 32'hffff_ffff);
    rd(OFF_RISE_EN, 32'h0007_ffff);
    rd(32'h18, 32'h0, RESP_SLVERR);
    wr(32'h18, 32'h1, RESP_SLVERR);
    // sticky pending, write zero, polarity change
    wr(OFF_RISE_EN, 32'h8);
    wr(OFF_LINE_PEND, 32'h0007_ffff);
    lvl[3] <= 1'b0;
    repeat (4) @(posedge clk);
    lvl[3] <= 1'b1;
    repeat (6) @(posedge clk);
    wr(OFF_LINE_PEND, 32'h0);
    rd(OFF_LINE_PEND, 32'h8);
    wr(OFF_RISE_EN, 32'h0);
    rd(OFF_LINE_PEND, 32'h0);
    // software trigger through the interrupt path
    wr(OFF_SW_TRIG, 32'h0);
    rd(OFF_LINE_PEND, 32'h0);
    wr(OFF_SW_TRIG, 32'h20);
    rd(OFF_LINE_PEND, 32'h20);
    chk({13'h0, irq}, 32'h20);
    wr(OFF_LINE_PEND, 32'h20);
    rd(OFF_SW_TRIG, 32'h0);
    rd(OFF_LINE_PEND, 32'h0);
    // event-only line: pulse but no pending
    wr(OFF_IRQ_MASK, 32'h0007_ff7f);
    wr(OFF_EVT_MASK, 32'h80);
    acc_clr <= 1'b1;
    @(posedge clk);
    acc_clr <= 1'b0;
    wr(OFF_SW_TRIG, 32'h80);
    repeat (3) @(posedge clk);
    chk({13'h0, acc}, 32'h80);
    rd(OFF_LINE_PEND, 32'h0);
    // edge arriving while the enable is rewritten is dropped
    wr(OFF_RISE_EN, 32'h200);
    wr(OFF_LINE_PEND, 32'h0007_ffff);
    lvl[9] <= 1'b1;
    @(posedge clk);
    wr(OFF_RISE_EN, 32'h200);
    repeat (6) @(posedge clk);
    rd(OFF_LINE_PEND, 32'h0);
    // byte lanes: only the second byte of the enable lands
    wr(OFF_RISE_EN, 32'h0007_ffff, 2'h0, 4'h2);
    rd(OFF_RISE_EN, 32'h0000_ff00);
    finish_test();
  end
endmodule
